//--- rtl/ext_decode_pkg.sv
package ext_decode_pkg;
	localparam int OPCODE_W = 16;
	localparam int DATA_ADDR_W = 12;
	localparam int PC_W = 21;
	localparam int LIT_W = 6;
	localparam int FILE_W = 8;
	localparam int BANK_W = 4;

	// Opcode fields
	localparam int OP_PREFIX_LSB = 6;
	localparam logic [9:0] OP_SUB_RETURN = 10'h3A7;
	localparam int OP_ACCESS_BIT = 8;
	localparam int OP_CLASS_MSB = 15;
	localparam int OP_CLASS_LSB = 12;

	// Byte and bit class bounds on the top nibble; low byte groups match opcode bits 11:9 and 11:10
	localparam logic [3:0] CLASS_FIRST = 4'h1;
	localparam logic [3:0] CLASS_LAST = 4'hB;
	localparam logic [2:0] LOW_BYTE_GROUP_A = 3'h1;
	localparam logic [1:0] LOW_BYTE_GROUP_B = 2'h1;

	// Access bank map
	localparam logic [FILE_W-1:0] INDEX_LIMIT = 8'h5F;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;

	localparam logic [DATA_ADDR_W-1:0] FRAME_PTR_RESET = 12'h000;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

	typedef struct packed {
		logic valid;
		logic [OPCODE_W-1:0] opcode;
	} instr_t;

	typedef struct packed {
		logic valid;
		logic indexed;
		logic [DATA_ADDR_W-1:0] addr;
	} data_ref_t;

	typedef struct packed {
		logic load;
		logic [PC_W-1:0] target;
	} pc_update_t;

	typedef enum logic [0:0] {
		ST_EXEC,
		ST_RETURN_NOP
	} seq_state_t;
endpackage

//--- rtl/indexed_offset_addressing_return.sv
// Behaviour
// - Subtract-and-return subtracts unsigned 6-bit literal 0..63 from frame pointer, writes it back.
// - Then it returns: program counter loaded from top of return stack.
// - It takes two instruction cycles; the second cycle does nothing.
// - Decoded as subtract-from-pointer with select 11; targets frame pointer; flags unchanged.
// - Extended set enable also turns on indexed literal offset addressing.
// - Extended off: a=0 uses access bank, a=1 uses bank select register bank.
// - Extended on, a=0, file address 5Fh or below is a frame pointer offset.
// - Indexing applies alike to every byte and bit instruction carrying the a bit.
// - Frame pointer 00h makes indexed operands land on the plain access bank places.
// - Indexed effective address is frame pointer plus opcode literal offset.
`timescale 1ns/1ps
module indexed_offset_addressing_return (
	input wire logic clk,
	input wire logic reset,
	input wire logic ext_enable,
	input wire ext_decode_pkg::instr_t instr,
	input wire logic [ext_decode_pkg::BANK_W-1:0] bank_select_register,
	input wire logic [ext_decode_pkg::PC_W-1:0] top_of_return_stack,
	input wire logic frame_ptr_write,
	input wire logic [ext_decode_pkg::DATA_ADDR_W-1:0] frame_ptr_write_value,
	output logic [ext_decode_pkg::DATA_ADDR_W-1:0] stack_frame_pointer,
	output ext_decode_pkg::data_ref_t data_ref,
	output ext_decode_pkg::pc_update_t pc_update,
	output logic return_stack_pop,
	output logic status_write_block,
	output logic instr_ready
);
	import ext_decode_pkg::*;

	// Sequencer
	seq_state_t state_ff;
	seq_state_t nxt_state;

	// Frame pointer
	logic [DATA_ADDR_W-1:0] frame_ptr_ff;
	logic [DATA_ADDR_W-1:0] nxt_frame_ptr;

	// Registered results
	logic ref_valid_ff;
	logic ref_indexed_ff;
	logic [DATA_ADDR_W-1:0] ref_addr_ff;
	logic pc_load_ff;
	logic [PC_W-1:0] pc_target_ff;
	logic pop_ff;
	logic flags_hold_ff;

	// Opcode decode
	logic take;
	logic is_sub_return;
	logic sub_return_taken;
	logic access_sel;
	logic [FILE_W-1:0] file_addr;
	logic [LIT_W-1:0] literal;
	logic [3:0] op_class;

	// Access-bit classes
	logic class_main;
	logic class_low_a;
	logic class_low_b;
	logic has_access_bit;

	// Address forming
	logic in_index_window;
	logic use_index;
	data_ref_t nxt_ref;

	// Return side
	pc_update_t nxt_pc_update;
	logic nxt_pop;
	logic nxt_flags_hold;

	// New instructions are refused while the dead second cycle runs
	assign instr_ready = (state_ff == ST_EXEC);
	assign take = instr.valid && instr_ready;

	assign op_class = instr.opcode[OP_CLASS_MSB:OP_CLASS_LSB];
	assign literal = instr.opcode[LIT_W-1:0];
	assign file_addr = instr.opcode[FILE_W-1:0];
	assign access_sel = instr.opcode[OP_ACCESS_BIT];

	// Only an extended opcode, so it is unknown with the set disabled
	assign is_sub_return = ext_enable
		&& (instr.opcode[OPCODE_W-1:OP_PREFIX_LSB] == OP_SUB_RETURN);
	assign sub_return_taken = take && is_sub_return;

	// One class test for all byte and bit forms, so every one indexes alike
	assign class_main = (op_class >= CLASS_FIRST) && (op_class <= CLASS_LAST);
	assign class_low_a = (op_class == 4'h0) && (instr.opcode[11:9] == LOW_BYTE_GROUP_A);
	assign class_low_b = (op_class == 4'h0) && (instr.opcode[11:10] == LOW_BYTE_GROUP_B);
	assign has_access_bit = class_main || class_low_a || class_low_b;

	// The window is judged on the raw file field, before any pointer is added
	assign in_index_window = (file_addr <= INDEX_LIMIT);
	assign use_index = ext_enable && !access_sel && in_index_window;

	always_comb begin
		nxt_ref.valid = take && has_access_bit;
		nxt_ref.indexed = use_index;
		if (access_sel) begin
			nxt_ref.addr = {bank_select_register, file_addr};
		end else if (use_index) begin
			// A zero pointer gives back file_addr itself, the low access area
			nxt_ref.addr = frame_ptr_ff + {4'h0, file_addr};
		end else if (in_index_window) begin
			nxt_ref.addr = {ACCESS_LOW_BANK, file_addr};
		end else begin
			nxt_ref.addr = {ACCESS_HIGH_BANK, file_addr};
		end
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_EXEC: begin
				if (sub_return_taken) begin
					nxt_state = ST_RETURN_NOP;
				end
			end
			ST_RETURN_NOP: begin
				nxt_state = ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= ST_EXEC;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// The instruction's own update beats a core write in the same cycle
	always_comb begin
		nxt_frame_ptr = frame_ptr_ff;
		if (sub_return_taken) begin
			// Wraps modulo the pointer width; software keeps the frame sane
			nxt_frame_ptr = frame_ptr_ff - {6'h00, literal};
		end else if (frame_ptr_write) begin
			nxt_frame_ptr = frame_ptr_write_value;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			frame_ptr_ff <= FRAME_PTR_RESET;
		end else begin
			frame_ptr_ff <= nxt_frame_ptr;
		end
	end

	always_comb begin
		nxt_pc_update.load = sub_return_taken;
		// Sampled with the opcode, so a later push cannot move the target
		nxt_pc_update.target = top_of_return_stack;
	end

	// Pop and flag hold fire with the reload, never on their own
	assign nxt_pop = sub_return_taken;
	assign nxt_flags_hold = sub_return_taken;

	// Field registers, one per concern
	always_ff @(posedge clk) begin
		if (reset) begin
			ref_valid_ff <= 1'b0;
		end else begin
			ref_valid_ff <= nxt_ref.valid;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ref_indexed_ff <= 1'b0;
		end else begin
			ref_indexed_ff <= nxt_ref.indexed;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ref_addr_ff <= FRAME_PTR_RESET;
		end else begin
			ref_addr_ff <= nxt_ref.addr;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pc_load_ff <= 1'b0;
		end else begin
			pc_load_ff <= nxt_pc_update.load;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pc_target_ff <= PC_RESET;
		end else begin
			pc_target_ff <= nxt_pc_update.target;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pop_ff <= 1'b0;
		end else begin
			pop_ff <= nxt_pop;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			flags_hold_ff <= 1'b0;
		end else begin
			flags_hold_ff <= nxt_flags_hold;
		end
	end

	// Outputs
	assign stack_frame_pointer = frame_ptr_ff;
	assign data_ref = '{valid: ref_valid_ff, indexed: ref_indexed_ff, addr: ref_addr_ff};
	assign pc_update = '{load: pc_load_ff, target: pc_target_ff};
	assign return_stack_pop = pop_ff;
	assign status_write_block = flags_hold_ff;
endmodule

//--- test/ext_decode_checker.sv
`timescale 1ns/1ps
module ext_decode_checker import ext_decode_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic ext_enable,
	input wire instr_t instr,
	input wire logic [BANK_W-1:0] bank_select_register,
	input wire logic [PC_W-1:0] top_of_return_stack,
	input wire logic [DATA_ADDR_W-1:0] stack_frame_pointer,
	input wire data_ref_t data_ref,
	input wire pc_update_t pc_update,
	input wire logic return_stack_pop,
	input wire logic status_write_block,
	input wire logic instr_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire take = instr.valid && instr_ready;
	wire srx = take && instr.opcode[15:6] == OP_SUB_RETURN;
	wire sr = srx && ext_enable;
	// Only one byte class is watched here; the bench also drives class 8
	wire byt = take && instr.opcode[15:12] == 4'h2;
	wire ix = byt && ext_enable && !instr.opcode[8] && instr.opcode[7:0] <= INDEX_LIMIT;
	a_sub_fp: assert property (sr |=> stack_frame_pointer == $past(stack_frame_pointer) - $past(instr.opcode[5:0]))
		else $error("fp sub");
	a_ret_pc: assert property (sr |=> pc_update.load && pc_update.target == $past(top_of_return_stack))
		else $error("pc load");
	a_ret_pop: assert property (sr |=> return_stack_pop && status_write_block)
		else $error("pop");
	a_nop_gap: assert property (sr |=> !instr_ready ##1 instr_ready)
		else $error("nop gap");
	a_no_ext: assert property (srx && !ext_enable |=> !return_stack_pop && !pc_update.load)
		else $error("no ext");
	a_pop_cause: assert property (return_stack_pop |-> $past(sr))
		else $error("pop cause");
	a_idx_addr: assert property (
		ix |=> data_ref.indexed && data_ref.addr == $past(stack_frame_pointer) + $past(instr.opcode[7:0]))
		else $error("idx addr");
	a_bank_sel: assert property (
		byt && instr.opcode[8] |=> data_ref.addr == {$past(bank_select_register), $past(instr.opcode[7:0])})
		else $error("bank");
	a_plain_acc: assert property (byt && !ext_enable |=> !data_ref.indexed && data_ref.valid)
		else $error("plain");
endmodule
bind indexed_offset_addressing_return ext_decode_checker ext_decode_checker_inst (.*);

//--- test/tb_indexed_offset_addressing_return.sv
`timescale 1ns/1ps
module tb_indexed_offset_addressing_return;
	import ext_decode_pkg::*;
	logic clk = 1'h0, reset = 1'h1, ext_enable = 1'h1, frame_ptr_write = 1'h0;
	instr_t instr = '0;
	logic [BANK_W-1:0] bank_select_register = 4'h3;
	logic [PC_W-1:0] top_of_return_stack = 21'h0;
	logic [DATA_ADDR_W-1:0] frame_ptr_write_value = 12'h0, stack_frame_pointer;
	data_ref_t data_ref;
	pc_update_t pc_update;
	logic return_stack_pop, status_write_block, instr_ready;
	int error_cnt = 0, num_checks = 0;
	indexed_offset_addressing_return indexed_offset_addressing_return_inst (.*);
	initial begin
		forever #12.5 clk = ~clk;
	end
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task issue(input logic [15:0] op);
		@(negedge clk) instr = {1'h1, op};
		@(negedge clk) instr = '0;
	endtask
	task setfp(input logic [11:0] v);
		@(negedge clk) frame_ptr_write = 1'h1;
		frame_ptr_write_value = v;
		@(negedge clk) frame_ptr_write = 1'h0;
	endtask
	task t_sub(input logic [5:0] k);
		ext_enable = 1'h1;
		setfp(12'h3FF);
		top_of_return_stack = 21'h1ABCD + k;
		issue({10'h3A7, k});
		chk("fp", stack_frame_pointer, 12'h3FF - k);
		chk("pc", pc_update, {1'h1, 21'h1ABCD + k});
		chk("pulses", {return_stack_pop, status_write_block, instr_ready}, 3'h6);
		// Offered in the dead cycle, so it must be dropped
		instr = {1'h1, 10'h3A7, 6'h01};
		@(negedge clk) instr = '0;
		chk("dead", {return_stack_pop, instr_ready, stack_frame_pointer}, {2'h1, 12'h3FF - k});
		$display("t_sub end");
	endtask
	task t_addr(input logic e, input logic [11:0] fpv, input logic [15:0] op, input logic [12:0] exp);
		ext_enable = e;
		setfp(fpv);
		issue(op);
		chk("addr", {data_ref.valid, data_ref.indexed, data_ref.addr}, {1'h1, exp});
		$display("t_addr end");
	endtask
	task t_noext;
		ext_enable = 1'h0;
		setfp(12'h040);
		issue(16'hE9C5);
		chk("noext", {return_stack_pop, pc_update.load, stack_frame_pointer}, 14'h0040);
		$display("t_noext end");
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		reset = 1'h0;
		t_sub(6'h23);
		t_sub(6'h3F);
		t_sub(6'h00);
		t_noext;
		t_addr(1'h1, 12'h080, 16'h2405, 13'h1085);
		t_addr(1'h1, 12'h000, 16'h2405, 13'h1005);
		t_addr(1'h1, 12'h0FF, 16'h8005, 13'h1104);
		t_addr(1'h1, 12'h080, 16'h2460, 13'h0F60);
		t_addr(1'h0, 12'h080, 16'h2405, 13'h0005);
		t_addr(1'h0, 12'h080, 16'h2505, 13'h0305);
		results;
	end
endmodule
